// [src/timer_unit_consts.vh]
// Register map, field positions and mode codes of the timer readback and timer-two control block
`ifndef TIMER_UNIT_CONSTS_VH
`define TIMER_UNIT_CONSTS_VH
// Register offsets
`define ADDR_TIMER1_RELOAD_LOW   8'h16
`define ADDR_TIMER1_COUNT_HIGH   8'h17
`define ADDR_TIMER1_COUNT_LOW    8'h18
`define ADDR_TIMER2_CONTROL      8'h19
`define ADDR_TIMER2_RELOAD_HIGH  8'h1a
// Register offsets of the unit kept outside this block; not decoded here, so reads of them return zero
`define ADDR_TIMER2_RELOAD_LOW   8'h1b
`define ADDR_TIMER2_COUNT_HIGH   8'h1c
`define ADDR_TIMER2_COUNT_LOW    8'h1d
// Timer-two control fields
`define CTL_HALT_BIT             7
`define CTL_START_HI             5
`define CTL_START_LO             4
`define CTL_AUTO_BIT             3
`define CTL_CLK_HI               1
`define CTL_CLK_LO               0
`define CTL_WRITE_MASK           8'hbb
// Start modes
`define START_NONE               2'h0
`define START_TX_END             2'h1
`define START_TRIM_NO_UF         2'h2
`define START_TRIM_UF            2'h3
// Clock sources
`define CLK_13M56                2'h0
`define CLK_212K                 2'h1
`define CLK_TIMER0_UF            2'h2
`define CLK_TIMER1_UF            2'h3
// Reset values, count step and received-bit halt count
`define RESET_BYTE               8'h00
`define RESET_WORD               16'h0000
`define COUNT_ONE                16'h0001
`define RX_BITS_TO_HALT          3'h4
`define RX_BITS_ZERO             3'h0
`define RX_BITS_STEP             3'h1
`endif

// [src/timer2_counter.v]
// Timer-two down-counter with start, halt, reload and underflow logic
`timescale 1ns/1ps
module timer2_counter (
  input  wire        i_core_clk,
  input  wire        i_srst,
  input  wire [7:0]  i_control,
  input  wire [15:0] i_reload_word,
  input  wire        i_start_pulse,
  input  wire        i_tick_13m56,
  input  wire        i_tick_212k,
  input  wire        i_timer0_underflow,
  input  wire        i_timer1_underflow,
  input  wire        i_tx_end,
  input  wire        i_trim_edge,
  input  wire        i_rx_bit,
  input  wire        i_rx_frame_start,
  output reg  [15:0] o_count,
  output reg         o_running,
  output reg         o_underflow
);
`include "timer_unit_consts.vh"

  wire [1:0] start_mode = i_control[`CTL_START_HI:`CTL_START_LO];
  wire [1:0] clk_sel    = i_control[`CTL_CLK_HI:`CTL_CLK_LO];
  wire       trimming   = start_mode[1];
  reg        tick;
  reg  [2:0] rx_bits;
  reg        start_evt;
  reg        stop_evt;
  reg        halt_evt;

  // Count clock selection; cascade inputs are one-cycle pulses
  always @* begin
    case (clk_sel)
      `CLK_13M56:     tick = i_tick_13m56;
      `CLK_212K:      tick = i_tick_212k;
      `CLK_TIMER0_UF: tick = i_timer0_underflow;
      `CLK_TIMER1_UF: tick = i_timer1_underflow;
      default:        tick = 1'b0;
    endcase
  end

  // Start and stop sources; trimming toggles on each positive edge
  always @* begin
    start_evt = i_start_pulse;
    stop_evt  = 1'b0;
    if (start_mode == `START_TX_END && i_tx_end) begin
      start_evt = 1'b1;
    end
    if (trimming && i_trim_edge) begin
      start_evt = ~o_running;
      stop_evt  = o_running;
    end
  end

  // Halt after four received bits; trimming modes ignore the halt bit
  always @* begin
    halt_evt = i_control[`CTL_HALT_BIT] && !trimming && o_running && i_rx_bit
               && (rx_bits == `RX_BITS_TO_HALT - `RX_BITS_STEP);
  end

  // Received bit counter, cleared at each frame start
  always @(posedge i_core_clk) begin
    if (i_srst || i_rx_frame_start) begin
      rx_bits <= `RX_BITS_ZERO;
    end else if (i_rx_bit && rx_bits != `RX_BITS_TO_HALT) begin
      rx_bits <= rx_bits + `RX_BITS_STEP;
    end
  end

  // Counter core; a start or an auto reload loads the live reload word, so a mid-count write lands at the next reload
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_count     <= `RESET_WORD;
      o_running   <= 1'b0;
      o_underflow <= 1'b0;
    end else begin
      o_underflow <= 1'b0;
      if (start_evt) begin
        o_count   <= i_reload_word;
        o_running <= 1'b1;
      end else if (stop_evt || halt_evt) begin
        o_running <= 1'b0;
      end else if (o_running && tick) begin
        if (o_count == `RESET_WORD) begin
          // Trimming without underflow never flags
          o_underflow <= (start_mode != `START_TRIM_NO_UF);
          if (i_control[`CTL_AUTO_BIT]) begin
            o_count <= i_reload_word;
          end else begin
            o_running <= 1'b0;
          end
        end else begin
          o_count <= o_count - `COUNT_ONE;
        end
      end
    end
  end
endmodule

// [src/timer1_timer2_regs.v]
// Register block for timer-one readback/reload low byte and timer-two control
`timescale 1ns/1ps
module timer1_timer2_regs (
  input  wire        i_core_clk,
  input  wire        i_srst,
  input  wire [7:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  input  wire [15:0] i_timer1_count,
  input  wire        i_timer1_start,
  input  wire [7:0]  i_timer1_reload_high,
  output reg  [15:0] o_timer1_load_word,
  input  wire [7:0]  i_timer2_reload_low,
  input  wire        i_timer2_start,
  input  wire        i_tick_13m56,
  input  wire        i_tick_212k,
  input  wire        i_timer0_underflow,
  input  wire        i_timer1_underflow,
  input  wire        i_tx_end,
  input  wire        i_trim_pin,
  input  wire        i_rx_bit,
  input  wire        i_rx_frame_start,
  input  wire        i_flag_clear,
  output wire [15:0] o_timer2_count,
  output wire        o_timer2_running,
  output wire        o_timer2_underflow,
  output reg         o_timer2_underflow_flag
);
`include "timer_unit_consts.vh"

  // ==========================================================
  // Registers
  reg  [7:0] timer1_reload_low;
  reg  [7:0] timer2_control;
  reg  [7:0] timer2_reload_high;
  reg        trim_meta;
  reg        trim_sync;
  reg        trim_prev;
  wire       trim_edge = trim_sync & ~trim_prev;

  // Software writes; reserved control bits are masked off on write
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      timer1_reload_low  <= `RESET_BYTE;
      timer2_control     <= `RESET_BYTE;
      timer2_reload_high <= `RESET_BYTE;
    end else if (i_wr) begin
      case (i_addr)
        `ADDR_TIMER1_RELOAD_LOW:  timer1_reload_low  <= i_wdata;
        // Reserved bits masked on write
        `ADDR_TIMER2_CONTROL:     timer2_control     <= i_wdata & `CTL_WRITE_MASK;
        `ADDR_TIMER2_RELOAD_HIGH: timer2_reload_high <= i_wdata;
        default: ;
      endcase
    end
  end

  // Timer-one load word latched only at its start, so a write mid-count is harmless
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_timer1_load_word <= `RESET_WORD;
    end else if (i_timer1_start) begin
      o_timer1_load_word <= {i_timer1_reload_high, timer1_reload_low};
    end
  end

  // ==========================================================
  // Trim pin synchroniser; the first stage feeds only the second
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      trim_meta <= 1'b0;
      trim_sync <= 1'b0;
      trim_prev <= 1'b0;
    end else begin
      trim_meta <= i_trim_pin;
      trim_sync <= trim_meta;
      trim_prev <= trim_sync;
    end
  end

  // ==========================================================
  // Timer-two counter
  timer2_counter u_timer2 (
    .i_core_clk         (i_core_clk),
    .i_srst             (i_srst),
    .i_control          (timer2_control),
    .i_reload_word      ({timer2_reload_high, i_timer2_reload_low}),
    .i_start_pulse      (i_timer2_start),
    .i_tick_13m56       (i_tick_13m56),
    .i_tick_212k        (i_tick_212k),
    .i_timer0_underflow (i_timer0_underflow),
    .i_timer1_underflow (i_timer1_underflow),
    .i_tx_end           (i_tx_end),
    .i_trim_edge        (trim_edge),
    .i_rx_bit           (i_rx_bit),
    .i_rx_frame_start   (i_rx_frame_start),
    .o_count            (o_timer2_count),
    .o_running          (o_timer2_running),
    .o_underflow        (o_timer2_underflow)
  );

  // Sticky flag; a set in the same cycle as a clear wins
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_timer2_underflow_flag <= 1'b0;
    end else if (o_timer2_underflow) begin
      o_timer2_underflow_flag <= 1'b1;
    end else if (i_flag_clear) begin
      o_timer2_underflow_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the read strobe.
  // Count bytes are live; reading during reception gives no coherent pair.
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rdata <= `RESET_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        `ADDR_TIMER1_RELOAD_LOW:  o_rdata <= timer1_reload_low;
        `ADDR_TIMER1_COUNT_HIGH:  o_rdata <= i_timer1_count[15:8];
        `ADDR_TIMER1_COUNT_LOW:   o_rdata <= i_timer1_count[7:0];
        `ADDR_TIMER2_CONTROL:     o_rdata <= timer2_control;
        `ADDR_TIMER2_RELOAD_HIGH: o_rdata <= timer2_reload_high;
        default:                  o_rdata <= `RESET_BYTE;
      endcase
    end else begin
      o_rdata <= `RESET_BYTE;
    end
  end
endmodule

// [bench/timer_regs_monitor.sv]
// Port-level assertions for the timer readback and timer-two control block
`timescale 1ns/1ps
module timer_regs_monitor (
  input logic        i_core_clk,
  input logic        i_srst,
  input logic        i_rd,
  input logic [7:0]  o_rdata,
  input logic        i_timer1_start,
  input logic [7:0]  i_timer1_reload_high,
  input logic [15:0] o_timer1_load_word,
  input logic        i_timer2_start,
  input logic [7:0]  i_timer2_reload_low,
  input logic        i_flag_clear,
  input logic [15:0] o_timer2_count,
  input logic        o_timer2_running,
  input logic        o_timer2_underflow,
  input logic        o_timer2_underflow_flag
);
  // ==========================================================
  // Checks, all in the core clock domain
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // Read data only stands in the cycle after a read strobe
  property p_rd_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_t1_load; i_timer1_start |=> o_timer1_load_word[15:8] == $past(i_timer1_reload_high);
  endproperty
  a_t1_load: assert property (p_t1_load) else $error("timer one load word wrong");
  property p_start; i_timer2_start |=> o_timer2_running
    && o_timer2_count[7:0] == $past(i_timer2_reload_low);
  endproperty
  a_start: assert property (p_start) else $error("start did not load");
  property p_uf_zero; o_timer2_underflow |-> $past(o_timer2_count) == 16'h0000; endproperty
  a_uf_zero: assert property (p_uf_zero) else $error("underflow off zero");
  property p_uf_flag; o_timer2_underflow |=> o_timer2_underflow_flag; endproperty
  a_uf_flag: assert property (p_uf_flag) else $error("flag not set");
  property p_flag_hold; o_timer2_underflow_flag && !i_flag_clear |=> o_timer2_underflow_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  property p_flag_clr; i_flag_clear && !o_timer2_underflow |=> !o_timer2_underflow_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
  // A timer that stays stopped must not move its count
  property p_stop_hold; !o_timer2_running ##1 !o_timer2_running |-> $stable(o_timer2_count);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped");
endmodule
bind timer1_timer2_regs timer_regs_monitor timer_regs_monitor_inst (.*);

// [bench/testbench.sv]
// Self-checking bench for the timer readback and timer-two control block
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Stimulus signals; p holds every one-cycle pulse input
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, trim = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rl = 8'h00, t1h = 8'h00;
  logic [15:0] t1c = 16'h0000;
  logic [9:0]  p = 10'h000;
  wire  [7:0]  rdata;
  wire  [15:0] t1w, cnt;
  wire         run, uf, flag;
  int          n_errors = 0, check_count = 0;
  timer1_timer2_regs timer1_timer2_regs_inst (
    .i_core_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_timer1_count(t1c), .i_timer1_start(p[9]),
    .i_timer1_reload_high(t1h), .o_timer1_load_word(t1w), .i_timer2_reload_low(rl),
    .i_timer2_start(p[8]), .i_tick_13m56(p[0]), .i_tick_212k(p[1]),
    .i_timer0_underflow(p[2]), .i_timer1_underflow(p[3]), .i_tx_end(p[4]),
    .i_trim_pin(trim), .i_rx_bit(p[5]), .i_rx_frame_start(p[6]), .i_flag_clear(p[7]),
    .o_timer2_count(cnt), .o_timer2_running(run), .o_timer2_underflow(uf),
    .o_timer2_underflow_flag(flag));
  // 25 MHz core clock
  initial forever #20 clk = ~clk;
  // ==========================================================
  // Access and compare tasks
  task chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t ns: saw %h, expected %h", $time, s, e);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe, so sample just past that edge
  task rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(16'(rdata), 16'(e));
  endtask
  task pulse(input int b);
    @(posedge clk);
    p[b] <= 1'b1;
    @(posedge clk);
    p[b] <= 1'b0;
    #1;
  endtask
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // Register map, reserved bits and timer-one readback
    rreg(8'h19, 8'h00);
    wreg(8'h19, 8'hff);
    rreg(8'h19, 8'hbb);
    t1c <= 16'h1234;
    rreg(8'h17, 8'h12);
    rreg(8'h18, 8'h34);
    rreg(8'h30, 8'h00);
    // Timer-one reload low only reaches the load word at a start event
    t1h <= 8'h77;
    wreg(8'h16, 8'h5c);
    #1 chk(t1w, 16'h0000);
    rreg(8'h16, 8'h5c);
    pulse(9);
    chk(t1w, 16'h775c);
    // Auto reload walk, then a deferred reload high write
    rl <= 8'h01;
    wreg(8'h19, 8'h08);
    pulse(8);
    chk(cnt, 16'h0001);
    pulse(0);
    chk(cnt, 16'h0000);
    pulse(0);
    chk({uf, cnt[14:0]}, 16'h8001);
    @(posedge clk);
    #1 chk(16'(flag), 16'h0001);
    pulse(7);
    chk(16'(flag), 16'h0000);
    wreg(8'h1a, 8'ha5);
    #1 chk(cnt, 16'h0001);
    rreg(8'h1a, 8'ha5);
    pulse(8);
    chk(cnt, 16'ha501);
    wreg(8'h1a, 8'h00);
    // Without auto reload the timer stops at zero
    wreg(8'h19, 8'h00);
    pulse(8);
    pulse(0);
    pulse(0);
    chk({uf, run, cnt[13:0]}, 16'h8000);
    // Each clock source counts, a foreign source does not
    rl <= 8'h02;
    for (int cs = 0; cs < 4; cs++) begin
      wreg(8'h19, 8'(cs));
      pulse(8);
      pulse((cs + 1) % 4);
      chk(cnt, 16'h0002);
      pulse(cs);
      chk(cnt, 16'h0001);
    end
    // Halt after four received bits, ignored in a trimming mode
    rl <= 8'h05;
    for (int m = 0; m < 2; m++) begin
      wreg(8'h19, (m != 0) ? 8'ha0 : 8'h80);
      pulse(8);
      pulse(6);
      repeat (3) pulse(5);
      chk(16'(run), 16'h0001);
      pulse(5);
      chk(16'(run), 16'(m));
    end
    // Trim pin rising edges stop, then restart the running timer
    trim <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(16'(run), 16'h0000);
    trim <= 1'b0;
    repeat (3) @(posedge clk);
    trim <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({run, cnt[14:0]}, 16'h8005);
    // End of transmission only starts the timer in its own mode
    wreg(8'h19, 8'h80);
    pulse(6);
    repeat (4) pulse(5);
    pulse(4);
    chk(16'(run), 16'h0000);
    wreg(8'h19, 8'h10);
    pulse(4);
    chk({run, cnt[14:0]}, 16'h8005);
    // Trimming modes: only the with-underflow mode raises an underflow
    rl <= 8'h00;
    for (int m = 2; m < 4; m++) begin
      wreg(8'h19, 8'(m << 4));
      pulse(7);
      pulse(8);
      pulse(0);
      chk(16'(uf), 16'(m - 2));
    end
    end_sim();
  end
endmodule
